// *** hw/dmaf_fill.sv ***
/*
 * single-address dma channel in memory fill mode: writes the fill value over
 * the source region, checks the channel settings, splits bursts at 32-dw
 * boundaries.
 * assumes a memory-side controller on ref_clk that takes a beat when
 * mem_wr.req and mem_ready are both high, and a register master on ref_clk.
 */
//
// Contract
// - fill writes fill value over source region
// - wait request delay between bus requests
// - bad settings set config error, no transfer
// - zero increment in fill is config error
// - destination registers ignored
// - address, increment, count aligned to size; a downward 8-byte or burst fill needs address bits 2:0 at 7
// - no burst crosses 32-dw boundary
// - unaligned start splits into smaller bursts
// - split mode 0: short burst then full
// - split mode 1: boundary split keeps ownership
`timescale 1ns/1ps
`include "dmaf_consts.svh"

module dmaf_fill
    import dmaf_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // memory write channel
    output dmaf_wr_t         mem_wr,
    input  wire logic        mem_ready,
    // interrupt
    output logic             irq
);

    dmaf_regs_t r_ff;
    dmaf_regs_t nxt_r;

    // decoded channel settings
    logic [2:0]  transfer_size_field;
    logic        is_burst;
    logic [2:0]  low_mask;
    logic [1:0]  beat_log;
    logic [5:0]  sdw;
    logic        neg;
    logic        fill_mode;
    logic        cfg_bad;
    logic [31:0] rem_beats;
    logic [5:0]  dwidx;
    logic [5:0]  room;
    logic [5:0]  align;
    logic [5:0]  cand;
    logic [5:0]  plan_len;
    logic [2:0]  addr_want;
    logic        accept;

    // geometry of the programmed transfer size
    always_comb begin
        transfer_size_field      = r_ff.ctrl[`DMAF_CTL_TRANSFER_SIZE_FIELD_HI:`DMAF_CTL_TRANSFER_SIZE_FIELD_LO];
        is_burst  = (transfer_size_field >= `DMAF_TRANSFER_SIZE_FIELD_4DW);
        low_mask  = (transfer_size_field == 3'h0) ? 3'h0 : (transfer_size_field == 3'h1) ? 3'h1 :
                    (transfer_size_field == 3'h2) ? 3'h3 : 3'h7;
        beat_log  = is_burst ? 2'h3 : transfer_size_field[1:0];
        sdw       = is_burst ? (6'h01 << (transfer_size_field - 3'h2)) : 6'h01;
        neg       = r_ff.src_inc[31];
        fill_mode = !r_ff.ctrl[`DMAF_CTL_EXT_REQUEST_SEL] && r_ff.ctrl[`DMAF_CTL_SNGL]
                    && !r_ff.ctrl[`DMAF_CTL_DIR];
        rem_beats = r_ff.count >> beat_log;
        dwidx     = {1'b0, r_ff.src_addr[7:3]};
        // distance to the 32-dw boundary in the direction of travel
        room      = neg ? (dwidx + 6'h01) : (`DMAF_BOUNDARY_DW - dwidx);
        align     = neg ? ((dwidx & (sdw - 6'h01)) + 6'h01)
                        : (sdw - (dwidx & (sdw - 6'h01)));
        addr_want = (neg && low_mask == 3'h7) ? 3'h7 : 3'h0;
        accept    = r_ff.wr.req && mem_ready;
    end

    // settings check; only the fill mode is served by this channel
    always_comb begin
        cfg_bad = !fill_mode;
        if ((r_ff.src_addr[2:0] & low_mask) != addr_want) begin
            cfg_bad = 1'b1;
        end
        if ((r_ff.count[2:0] & low_mask) != 3'h0) begin
            cfg_bad = 1'b1;
        end
        if (r_ff.src_inc == `DMAF_RST_WORD) begin
            cfg_bad = 1'b1;
        end
        if (is_burst) begin
            if (r_ff.src_inc != `DMAF_INC_POS8 && r_ff.src_inc != `DMAF_INC_NEG8) begin
                cfg_bad = 1'b1;
            end
        end else if ((r_ff.src_inc[2:0] & low_mask) != 3'h0) begin
            cfg_bad = 1'b1;
        end
    end

    // length of the next burst piece
    always_comb begin
        if (!is_burst) begin
            cand = 6'h01;
        end else if (!r_ff.ctrl[`DMAF_CTL_SPLIT]) begin
            cand = align;
        end else begin
            cand = (r_ff.burst_left == 6'h00) ? sdw : r_ff.burst_left;
            if (room < cand) begin
                cand = room;
            end
        end
        plan_len = (rem_beats < {26'h0, cand}) ? rem_beats[5:0] : cand;
    end

    // next state of the whole channel
    always_comb begin
        nxt_r       = r_ff;
        nxt_r.rdata = `DMAF_RST_WORD;

        // register reads answer in the following cycle
        if (reg_rd) begin
            unique case (reg_addr)
                `DMAF_OFS_CTRL:     nxt_r.rdata = {16'h0000, r_ff.ctrl};
                `DMAF_OFS_STATUS:   nxt_r.rdata = {29'h0, r_ff.sticky, r_ff.st != st_idle};
                `DMAF_OFS_MASK:     nxt_r.rdata = {29'h0, r_ff.mask};
                `DMAF_OFS_SRC_ADDR: nxt_r.rdata = r_ff.src_addr;
                `DMAF_OFS_SRC_INC:  nxt_r.rdata = r_ff.src_inc;
                `DMAF_OFS_COUNT:    nxt_r.rdata = r_ff.count;
                `DMAF_OFS_FILL_LO:  nxt_r.rdata = r_ff.fill[31:0];
                `DMAF_OFS_FILL_HI:  nxt_r.rdata = r_ff.fill[63:32];
                `DMAF_OFS_DST_ADDR: nxt_r.rdata = r_ff.dst_addr;
                `DMAF_OFS_DST_INC:  nxt_r.rdata = r_ff.dst_inc;
                default:            nxt_r.rdata = `DMAF_RST_WORD;
            endcase
        end

        // writes; channel settings are frozen while a transfer runs
        if (reg_wr) begin
            if (reg_addr == `DMAF_OFS_STATUS) begin
                nxt_r.sticky = r_ff.sticky & ~reg_wdata[2:1];
            end
            if (reg_addr == `DMAF_OFS_MASK) begin
                nxt_r.mask = reg_wdata[2:0];
            end
            if (r_ff.st == st_idle) begin
                unique case (reg_addr)
                    `DMAF_OFS_CTRL: begin
                        nxt_r.ctrl       = reg_wdata[15:0] & 16'hFFFE;
                        nxt_r.start_pend = reg_wdata[`DMAF_CTL_START];
                    end
                    `DMAF_OFS_SRC_ADDR: nxt_r.src_addr = reg_wdata;
                    `DMAF_OFS_SRC_INC:  nxt_r.src_inc  = reg_wdata;
                    `DMAF_OFS_COUNT:    nxt_r.count    = reg_wdata;
                    `DMAF_OFS_FILL_LO:  nxt_r.fill[31:0]  = reg_wdata;
                    `DMAF_OFS_FILL_HI:  nxt_r.fill[63:32] = reg_wdata;
                    // stored for software only, never steers the channel
                    `DMAF_OFS_DST_ADDR: nxt_r.dst_addr = reg_wdata;
                    `DMAF_OFS_DST_INC:  nxt_r.dst_inc  = reg_wdata;
                    default: ;
                endcase
            end
        end

        // channel sequencer; hardware sets come after the clears so set wins
        unique case (r_ff.st)
            st_idle: begin
                if (r_ff.start_pend) begin
                    nxt_r.start_pend = 1'b0;
                    nxt_r.st         = st_check;
                end
            end
            st_check: begin
                nxt_r.burst_left = 6'h00;
                if (cfg_bad) begin
                    nxt_r.sticky[`DMAF_ST_CFGERR] = 1'b1;
                    nxt_r.st = st_idle;
                end else begin
                    nxt_r.st = st_plan;
                end
            end
            st_plan: begin
                if (rem_beats == `DMAF_RST_WORD) begin
                    nxt_r.sticky[`DMAF_ST_DONE] = 1'b1;
                    nxt_r.st = st_idle;
                end else begin
                    // write-only beat carrying the fill value
                    nxt_r.wr.req  = 1'b1;
                    nxt_r.wr.addr = r_ff.src_addr;
                    nxt_r.wr.data = r_ff.fill;
                    nxt_r.wr.size = transfer_size_field;
                    nxt_r.wr.len  = plan_len;
                    nxt_r.wr.last = (plan_len == 6'h01);
                    nxt_r.wr.lock = r_ff.ctrl[`DMAF_CTL_SPLIT] && is_burst
                                    && (plan_len < cand || cand < sdw)
                                    && (plan_len < rem_beats[5:0] || rem_beats > 32'h0000_003F)
                                    && (r_ff.burst_left == 6'h00 ? sdw : r_ff.burst_left)
                                       > plan_len;
                    nxt_r.beat_left = plan_len;
                    nxt_r.st        = st_burst;
                end
            end
            st_burst: begin
                if (accept) begin
                    // advance by the programmed increment after every beat
                    nxt_r.src_addr  = r_ff.src_addr + r_ff.src_inc;
                    nxt_r.count     = r_ff.count - (32'h0000_0001 << beat_log);
                    nxt_r.beat_left = r_ff.beat_left - 6'h01;
                    nxt_r.wr.addr   = r_ff.src_addr + r_ff.src_inc;
                    nxt_r.wr.last   = (r_ff.beat_left == 6'h02);
                    if (r_ff.beat_left == 6'h01) begin
                        nxt_r.wr.req   = 1'b0;
                        nxt_r.wr.lock  = 1'b0;
                        nxt_r.burst_left = r_ff.wr.lock ?
                            ((r_ff.burst_left == 6'h00 ? sdw : r_ff.burst_left)
                             - r_ff.wr.len) : 6'h00;
                        nxt_r.gap = r_ff.ctrl[`DMAF_CTL_DLY_HI:`DMAF_CTL_DLY_LO];
                        if (nxt_r.count == `DMAF_RST_WORD) begin
                            nxt_r.sticky[`DMAF_ST_DONE] = 1'b1;
                            nxt_r.st = st_idle;
                        end else if (r_ff.wr.lock) begin
                            nxt_r.st = st_plan;
                        end else begin
                            nxt_r.st = st_gap;
                        end
                    end
                end
            end
            st_gap: begin
                // hold off the next ownership request for the programmed delay
                if (r_ff.gap == 8'h00) begin
                    nxt_r.st = st_plan;
                end else begin
                    nxt_r.gap = r_ff.gap - 8'h01;
                end
            end
        endcase

        nxt_r.irq = |(nxt_r.sticky & nxt_r.mask[2:1]);
    end

    // single register stage for the whole channel
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            r_ff <= '0;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign reg_rdata = r_ff.rdata;
    assign mem_wr    = r_ff.wr;
    assign irq       = r_ff.irq;

    // assertion helpers: cycles with no request, and whether that gap is free
    logic [8:0] low_cnt_ff;
    logic       unl_ff;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            low_cnt_ff <= 9'h000;
            unl_ff     <= 1'b0;
        end else begin
            low_cnt_ff <= r_ff.wr.req ? 9'h000 :
                          (low_cnt_ff == 9'h1FF ? low_cnt_ff : low_cnt_ff + 9'h001);
            if (accept && r_ff.wr.last) begin
                unl_ff <= !r_ff.wr.lock && (r_ff.count != (32'h0000_0001 << beat_log));
            end else if (r_ff.st == st_idle) begin
                unl_ff <= 1'b0;
            end
        end
    end

    default clocking dmaf_cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    AST_FILL_DATA: assert property (mem_wr.req |-> mem_wr.data == r_ff.fill)
        else $error("fill beat carries a value other than the fill register");
    AST_REQ_DELAY: assert property ($rose(mem_wr.req) && unl_ff |->
                                    low_cnt_ff > {1'b0, r_ff.ctrl[15:8]})
        else $error("bus request came before the request delay ran out");
    AST_CFG_STOP: assert property (r_ff.st == st_check && cfg_bad |=>
                                   r_ff.sticky[1] && r_ff.st == st_idle ##1 !mem_wr.req)
        else $error("bad settings did not stop the channel with an error");
    AST_ZERO_INC: assert property (r_ff.st == st_check && r_ff.src_inc == 32'h0000_0000
                                   |=> r_ff.sticky[1])
        else $error("zero source increment accepted in fill mode");
    AST_ALIGN: assert property (r_ff.st == st_check && (r_ff.count[2:0] & low_mask) != 3'h0
                                |=> r_ff.sticky[1] && !mem_wr.req)
        else $error("misaligned byte count accepted");
    AST_BOUNDARY: assert property (mem_wr.req && is_burst |->
                                   r_ff.beat_left <= room)
        else $error("burst would cross a 32-dw boundary");
    // in split mode 0, only the first beat of a full piece sits on the size alignment
    AST_MODE0: assert property (mem_wr.req && is_burst && !r_ff.ctrl[4]
                                && mem_wr.len == sdw && r_ff.beat_left == mem_wr.len |->
                                (mem_wr.addr[8:3] & (sdw - 6'h01)) ==
                                (neg ? sdw - 6'h01 : 6'h00))
        else $error("full burst started off the size alignment");
    AST_LOCKED: assert property (accept && mem_wr.last && mem_wr.lock |=>
                                 !mem_wr.req ##1 mem_wr.req)
        else $error("locked split piece did not follow at once");
    AST_ADVANCE: assert property (accept && !mem_wr.last |=> mem_wr.req &&
                                  mem_wr.addr == $past(mem_wr.addr) + r_ff.src_inc)
        else $error("address did not advance by the increment");

endmodule

// *** hw/dmaf_consts.svh ***
/*
 * register offsets, field positions, reset values and fixed figures of the
 * memory fill dma channel.
 * assumes a byte-addressed register port with 32-bit words on aligned offsets.
 */
`ifndef DMAF_CONSTS_SVH
`define DMAF_CONSTS_SVH

// register offsets (byte addresses)
`define DMAF_OFS_CTRL     8'h00
`define DMAF_OFS_STATUS   8'h04
`define DMAF_OFS_MASK     8'h08
`define DMAF_OFS_SRC_ADDR 8'h0C
`define DMAF_OFS_SRC_INC  8'h10
`define DMAF_OFS_COUNT    8'h14
`define DMAF_OFS_FILL_LO  8'h18
`define DMAF_OFS_FILL_HI  8'h1C
`define DMAF_OFS_DST_ADDR 8'h20
`define DMAF_OFS_DST_INC  8'h24

// chan_control_reg fields
`define DMAF_CTL_START    0
`define DMAF_CTL_EXT_REQUEST_SEL    1
`define DMAF_CTL_SNGL     2
`define DMAF_CTL_DIR      3
`define DMAF_CTL_SPLIT    4
`define DMAF_CTL_TRANSFER_SIZE_FIELD_LO  5
`define DMAF_CTL_TRANSFER_SIZE_FIELD_HI  7
`define DMAF_CTL_DLY_LO   8
`define DMAF_CTL_DLY_HI   15

// chan_status_reg fields, mask register uses the same layout
`define DMAF_ST_ACTIVE    0
`define DMAF_ST_CFGERR    1
`define DMAF_ST_DONE      2

// reset values
`define DMAF_RST_CTRL     16'h0000
`define DMAF_RST_WORD     32'h0000_0000
`define DMAF_RST_FILL     64'h0000_0000_0000_0000

// transfer size codes and burst geometry
`define DMAF_TRANSFER_SIZE_FIELD_8B      3'h3
`define DMAF_TRANSFER_SIZE_FIELD_4DW     3'h4
`define DMAF_BOUNDARY_DW  6'h20
`define DMAF_INC_POS8     32'h0000_0008
`define DMAF_INC_NEG8     32'hFFFF_FFF8

`endif

// *** hw/dmaf_pkg.sv ***
/*
 * types of the memory fill dma channel.
 * assumes dmaf_consts.svh is on the include path.
 */
package dmaf_pkg;

    typedef enum logic [2:0] {
        st_idle,
        st_check,
        st_plan,
        st_burst,
        st_gap
    } dmaf_state_t;

    // one write beat toward the memory side
    typedef struct packed {
        logic        req;
        logic [31:0] addr;
        logic [63:0] data;
        logic [2:0]  size;
        logic [5:0]  len;
        logic        last;
        logic        lock;
    } dmaf_wr_t;

    // complete state of the channel
    typedef struct packed {
        logic [15:0] ctrl;
        logic [2:1]  sticky;
        logic [2:0]  mask;
        logic [31:0] src_addr;
        logic [31:0] src_inc;
        logic [31:0] count;
        logic [63:0] fill;
        logic [31:0] dst_addr;
        logic [31:0] dst_inc;
        logic        start_pend;
        dmaf_state_t st;
        logic [5:0]  burst_left;
        logic [5:0]  beat_left;
        logic [7:0]  gap;
        dmaf_wr_t    wr;
        logic [31:0] rdata;
        logic        irq;
    } dmaf_regs_t;

endpackage

// *** dv/dmaf_mem_model.sv ***
/*
 * memory-side write controller model facing the fill channel.
 * assumes the channel drives dmaf_wr_t on ref_clk; slow asks for stalls.
 */
`timescale 1ns/1ps
module dmaf_mem_model
    import dmaf_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // write channel
    input  dmaf_wr_t  mem_wr,
    output logic      mem_ready,
    // test control and result
    input  wire logic slow,
    output int        err_cnt
);
    logic [1:0]  phase_ff;
    logic        held_ff;
    logic        mid_ff;
    dmaf_wr_t    prev_ff;
    logic [31:0] acc_ff;
    logic        acc;
    logic        bad;

    // slow takes one beat in four, so stalls also land inside pieces
    assign mem_ready = !slow || phase_ff == 2'h3;
    assign acc = mem_wr.req && mem_ready;

    // a stalled beat must stand; a piece never straddles 256 bytes
    always_comb begin
        bad = held_ff && prev_ff !== mem_wr;
        if (acc && mid_ff && mem_wr.addr[31:8] != acc_ff[31:8]) begin
            bad = 1'b1;
        end
    end

    // stall phase, last accepted beat and error tally
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            phase_ff <= 2'h0;
            held_ff  <= 1'b0;
            mid_ff   <= 1'b0;
            prev_ff  <= '0;
            acc_ff   <= 32'h0000_0000;
            err_cnt  <= 0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
            held_ff  <= mem_wr.req && !mem_ready;
            prev_ff  <= mem_wr;
            err_cnt  <= err_cnt + int'(bad);
            if (acc) begin
                acc_ff <= mem_wr.addr;
                mid_ff <= !mem_wr.last;
            end
        end
    end
endmodule

// *** dv/dmaf_fill_bench.sv ***
/*
 * self-checking bench of the fill channel: register tasks, fill runs,
 * settings errors and interrupt handling.
 * assumes dmaf_pkg is compiled first and dmaf_consts.svh is on the path.
 */
`timescale 1ns/1ps
`include "dmaf_consts.svh"
module dmaf_fill_bench
    import dmaf_pkg::*;
;
    localparam logic [31:0] FM   = 32'h0000_0004;
    localparam logic [63:0] FILL = 64'hC0DE_5A5A_0F0F_1234;
    logic        ref_clk   = 1'b0;
    logic        nrst      = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic        slow      = 1'b0;
    logic [31:0] reg_rdata;
    dmaf_wr_t    mem_wr;
    logic        mem_ready;
    logic        irq;
    int          model_err;
    int          miscompares = 0;
    int          cmp_count   = 0;
    int          gap_seen    = 0;
    int          low_cnt     = 0;
    logic        pfirst      = 1'b1;
    logic [2:0]  sz_seen     = 3'h0;
    logic [31:0] rv;
    logic [31:0] qa[$];
    logic [63:0] qd[$];
    logic [5:0]  ql[$];
    logic        qk[$];

    dmaf_fill dmaf_fill_i (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .mem_wr(mem_wr), .mem_ready(mem_ready), .irq(irq));
    dmaf_mem_model dmaf_mem_model_i (.ref_clk(ref_clk), .nrst(nrst), .mem_wr(mem_wr),
        .mem_ready(mem_ready), .slow(slow), .err_cnt(model_err));

    always #2.5 ref_clk = ~ref_clk;

    // beat recorder: pieces, lock bits and the idle gap before the latest piece
    always @(posedge ref_clk) begin
        if (mem_wr.req === 1'b1 && mem_ready === 1'b1) begin
            qa.push_back(mem_wr.addr);
            qd.push_back(mem_wr.data);
            sz_seen = mem_wr.size;
            if (pfirst) begin
                ql.push_back(mem_wr.len);
                gap_seen = low_cnt;
            end
            pfirst = mem_wr.last;
            if (mem_wr.last) begin
                qk.push_back(mem_wr.lock);
                low_cnt = 0;
            end
        end else if (mem_wr.req !== 1'b1) begin
            low_cnt = low_cnt + 1;
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    function automatic logic [31:0] ctl(input logic [31:0] m, input logic s,
                                        input logic [2:0] z, input logic [7:0] dly);
        return m | {27'h0, s, 4'h0} | {24'h0, z, 5'h0} | {16'h0, dly, 8'h0};
    endfunction

    // one run: program, start, poll status, clear it, then compare the beats
    task automatic rf(input logic [31:0] c, input logic [31:0] sa, input logic [31:0] inc,
                      input logic [31:0] cnt, input logic [2:0] st, input int nb,
                      input logic ei);
        int          i;
        logic [31:0] msk;
        msk = inc[31] ? 32'hFFFF_FFF8 : 32'hFFFF_FFFF;
        qa.delete();
        qd.delete();
        ql.delete();
        qk.delete();
        reg_write(`DMAF_OFS_SRC_ADDR, sa);
        reg_write(`DMAF_OFS_SRC_INC, inc);
        reg_write(`DMAF_OFS_COUNT, cnt);
        reg_write(`DMAF_OFS_CTRL, c | 32'h0000_0001);
        rv = 32'h0000_0000;
        i = 0;
        while (rv[2:1] === 2'b00 && i < 300) begin
            reg_read(`DMAF_OFS_STATUS, rv);
            i++;
        end
        if (i >= 300) begin
            miscompares++;
            print_verdict;
        end
        @(posedge ref_clk);
        #1;
        check(rv, {29'h0, st});
        check(irq, ei);
        reg_write(`DMAF_OFS_STATUS, 32'h0000_0006);
        reg_read(`DMAF_OFS_STATUS, rv);
        check(rv, 32'h0000_0000);
        check(irq, 1'b0);
        check(qa.size(), nb);
        if (nb > 0) check(sz_seen, c[7:5]);
        for (i = 0; i < qa.size(); i++) begin
            check(qa[i] & msk, (sa + i * inc) & msk);
            check(qd[i], FILL);
        end
    endtask

    initial begin
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        // reset values, unmapped space and ignored destination registers
        reg_read(`DMAF_OFS_CTRL, rv);
        check(rv, `DMAF_RST_WORD);
        reg_read(`DMAF_OFS_MASK, rv);
        check(rv, `DMAF_RST_WORD);
        reg_read(`DMAF_OFS_COUNT, rv);
        check(rv, `DMAF_RST_WORD);
        reg_write(8'h44, 32'hFFFF_FFFF);
        reg_read(8'h44, rv);
        check(rv, 32'h0000_0000);
        reg_write(`DMAF_OFS_DST_ADDR, 32'h1234_5679);
        reg_write(`DMAF_OFS_DST_INC, 32'h0000_0003);
        reg_write(`DMAF_OFS_FILL_LO, FILL[31:0]);
        reg_write(`DMAF_OFS_FILL_HI, FILL[63:32]);
        reg_write(`DMAF_OFS_MASK, 32'h0000_0006);
        reg_read(`DMAF_OFS_FILL_HI, rv);
        check(rv, FILL[63:32]);
        // split mode 0 from an unaligned start, no delay then a delay of 5
        for (int d = 0; d < 10; d += 5) begin
            rf(ctl(FM, 0, 3'h4, d[7:0]), 32'h0000_10A8, 32'h0000_0008, 32'h0000_0040,
               3'h4, 8, 1'b1);
            check(ql.size(), 3);
            check(ql[0], 6'h03);
            check(ql[1], 6'h04);
            check(gap_seen, d + 2);
        end
        // split mode 1 across a 256 byte line, memory stalling
        slow <= 1'b1;
        rf(ctl(FM, 1, 3'h4, 8'h03), 32'h0000_10E8, 32'h0000_0008, 32'h0000_0040,
           3'h4, 8, 1'b1);
        check(ql[0], 6'h03);
        check(qk[0], 1'b1);
        check(ql[1], 6'h01);
        check(ql[2], 6'h04);
        check(gap_seen, 5);
        slow <= 1'b0;
        // legal corner settings: downward fill and a 2-byte size
        rf(ctl(FM, 0, 3'h3, 8'h00), 32'h0000_0207, 32'hFFFF_FFF8, 32'h0000_0018,
           3'h4, 3, 1'b1);
        rf(ctl(FM, 0, 3'h1, 8'h00), 32'h0000_0302, 32'h0000_0002, 32'h0000_0006,
           3'h4, 3, 1'b1);
        // settings that must be refused with no beat
        rf(ctl(32'h0000_0006, 0, 3'h3, 8'h00), 32'h100, 32'h8, 32'h10, 3'h2, 0, 1'b1);
        rf(ctl(32'h0000_000C, 0, 3'h3, 8'h00), 32'h100, 32'h8, 32'h10, 3'h2, 0, 1'b1);
        rf(ctl(32'h0000_0000, 0, 3'h3, 8'h00), 32'h100, 32'h8, 32'h10, 3'h2, 0, 1'b1);
        rf(ctl(FM, 0, 3'h3, 8'h00), 32'h100, 32'h0, 32'h10, 3'h2, 0, 1'b1);
        rf(ctl(FM, 0, 3'h4, 8'h00), 32'h100, 32'h10, 32'h40, 3'h2, 0, 1'b1);
        rf(ctl(FM, 0, 3'h3, 8'h00), 32'h104, 32'h8, 32'h10, 3'h2, 0, 1'b1);
        rf(ctl(FM, 0, 3'h3, 8'h00), 32'h100, 32'h8, 32'h0C, 3'h2, 0, 1'b1);
        rf(ctl(FM, 0, 3'h2, 8'h00), 32'h102, 32'h4, 32'h10, 3'h2, 0, 1'b1);
        rf(ctl(FM, 0, 3'h3, 8'h00), 32'h200, 32'hFFFF_FFF8, 32'h10, 3'h2, 0, 1'b1);
        // masked events leave the interrupt low
        reg_write(`DMAF_OFS_MASK, 32'h0000_0000);
        rf(ctl(FM, 0, 3'h3, 8'h00), 32'h100, 32'h0, 32'h10, 3'h2, 0, 1'b0);
        check(model_err, 0);
        print_verdict;
    end
endmodule
